// ==== hw/regen_eoc_net.sv ====
// Top of the regenerator eoc network layer with two independent sides.
module regen_eoc_net (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic net_rx_valid,
  input wire logic net_rx_fcs_ok,
  input wire logic [3:0] net_rx_src,
  input wire logic [3:0] net_rx_dst,
  input wire logic net_rx_probe,
  input wire logic [3:0] net_rx_hop,
  input wire logic cus_rx_valid,
  input wire logic cus_rx_fcs_ok,
  input wire logic [3:0] cus_rx_src,
  input wire logic [3:0] cus_rx_dst,
  input wire logic cus_rx_probe,
  input wire logic [3:0] cus_rx_hop,
  input wire logic net_sync_word_loss,
  input wire logic cus_sync_word_loss,
  output logic [3:0] net_addr,
  output logic [3:0] cus_addr,
  output logic [1:0] net_state,
  output logic [1:0] cus_state,
  output logic net_app_valid,
  output logic [3:0] net_app_src,
  output logic cus_app_valid,
  output logic [3:0] cus_app_src,
  output logic to_cus_fwd,
  output logic [3:0] to_cus_dst,
  output logic [3:0] to_cus_hop,
  output logic to_cus_probe,
  output logic to_net_fwd,
  output logic [3:0] to_net_dst,
  output logic [3:0] to_net_hop,
  output logic to_net_probe,
  output logic net_resp,
  output logic [3:0] net_resp_hop,
  output logic net_resp_loss,
  output logic cus_resp,
  output logic [3:0] cus_resp_hop,
  output logic cus_resp_loss,
  output logic [7:0] resp_vendor,
  output logic [7:0] resp_version,
  output logic fwd_timeout
);
  typedef struct packed {
    logic [2:0] net_ls;
    logic [2:0] cus_ls;
    logic net_lsq;
    logic cus_lsq;
    logic [3:0] net_src;
    logic [3:0] cus_src;
    logic [3:0] to_cus_dst;
    logic to_cus_probe;
    logic [3:0] to_net_dst;
    logic to_net_probe;
    logic [23:0] net_tmr;
    logic [23:0] cus_tmr;
    logic timeout;
  } regen_top_t;
  regen_top_t r;
  regen_top_t next_r;
  regen_pkt_if net_pkt ();
  regen_pkt_if cus_pkt ();
  logic net_loss;
  logic cus_loss;
  logic [3:0] n_addr;
  logic [3:0] c_addr;
  regen_pkg::regen_state_t n_st;
  regen_pkg::regen_state_t c_st;
  logic n_proc;
  logic n_fwd;
  logic [3:0] n_hop;
  logic n_resp;
  logic c_proc;
  logic c_fwd;
  logic [3:0] c_hop;
  logic c_resp;

  assign net_loss = r.net_lsq;
  assign cus_loss = r.cus_lsq;
  assign net_pkt.valid = net_rx_valid & net_rx_fcs_ok; // RL1
  assign net_pkt.src = net_rx_src;
  assign net_pkt.dst = net_rx_dst;
  assign net_pkt.probe = net_rx_probe;
  assign net_pkt.hop = net_rx_hop;
  assign cus_pkt.valid = cus_rx_valid & cus_rx_fcs_ok; // RL1
  assign cus_pkt.src = cus_rx_src;
  assign cus_pkt.dst = cus_rx_dst;
  assign cus_pkt.probe = cus_rx_probe;
  assign cus_pkt.hop = cus_rx_hop;

  regen_side u_net ( // RL7
    .core_clk(core_clk), .rst_n(rst_n), .sync_loss(net_loss), .rx(net_pkt),
    .addr(n_addr), .state(n_st), .proc(n_proc), .fwd(n_fwd), .fwd_hop(n_hop), .resp(n_resp)
  );
  regen_side u_cus ( // RL18
    .core_clk(core_clk), .rst_n(rst_n), .sync_loss(cus_loss), .rx(cus_pkt),
    .addr(c_addr), .state(c_st), .proc(c_proc), .fwd(c_fwd), .fwd_hop(c_hop), .resp(c_resp)
  );

  always_comb begin
    next_r = r;
    next_r.net_ls = {r.net_ls[1:0], net_sync_word_loss};
    next_r.cus_ls = {r.cus_ls[1:0], cus_sync_word_loss};
    if (r.net_ls[1] == r.net_ls[2]) begin
      next_r.net_lsq = r.net_ls[2]; // RL25
    end
    if (r.cus_ls[1] == r.cus_ls[2]) begin
      next_r.cus_lsq = r.cus_ls[2]; // RL25
    end
    next_r.net_src = net_rx_src;
    next_r.cus_src = cus_rx_src;
    next_r.to_cus_dst = net_rx_dst;
    next_r.to_cus_probe = net_rx_probe;
    next_r.to_net_dst = cus_rx_dst;
    next_r.to_net_probe = cus_rx_probe;
    next_r.timeout = 1'b0;
    if (n_fwd && !cus_loss) begin
      next_r.net_tmr = 24'h0; // RL6
    end else if (r.net_tmr != 24'hffffff) begin
      next_r.net_tmr = r.net_tmr + 24'h1;
    end
    if (c_fwd && !net_loss) begin
      next_r.cus_tmr = 24'h0; // RL6
    end else if (r.cus_tmr != 24'hffffff) begin
      next_r.cus_tmr = r.cus_tmr + 24'h1;
    end
    if (r.net_tmr == 24'(regen_pkg::FWD_MAX_CYC) || r.cus_tmr == 24'(regen_pkg::FWD_MAX_CYC)) begin
      next_r.timeout = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.net_tmr <= 24'hffffff;
      r.cus_tmr <= 24'hffffff;
    end else begin
      r <= next_r;
    end
  end

  // Side handler outputs are registered, so they feed the ports directly, except fwd, which is gated by the opposite side's sync loss.
  assign net_addr = n_addr;
  assign cus_addr = c_addr;
  assign net_state = n_st;
  assign cus_state = c_st;
  assign net_app_valid = n_proc; // RL2
  assign net_app_src = r.net_src;
  assign cus_app_valid = c_proc; // RL2
  assign cus_app_src = r.cus_src;
  assign to_cus_fwd = n_fwd & ~cus_loss; // RL3 RL5
  assign to_cus_dst = r.to_cus_dst;
  assign to_cus_hop = n_hop;
  assign to_cus_probe = r.to_cus_probe;
  assign to_net_fwd = c_fwd & ~net_loss; // RL3 RL5
  assign to_net_dst = r.to_net_dst;
  assign to_net_hop = c_hop;
  assign to_net_probe = r.to_net_probe;
  assign net_resp = n_resp; // RL14
  assign net_resp_hop = n_hop;
  assign net_resp_loss = cus_loss; // RL14
  assign cus_resp = c_resp;
  assign cus_resp_hop = c_hop;
  assign cus_resp_loss = net_loss;
  assign resp_vendor = regen_pkg::VENDOR_ID;
  assign resp_version = regen_pkg::EOC_VERSION;
  assign fwd_timeout = r.timeout;
endmodule : regen_eoc_net

// ==== hw/regen_pkg.sv ====
// Package of constants and types for the regenerator eoc network layer.
// Functional notes
// RL1: Only packets with a good check sequence reach the network layer; bad ones vanish.
// RL2: Each valid packet is processed, forwarded or ignored; processing delivers source and data; the code delivers the source only, with no data port.
// RL3: Only regenerators forward; terminal units never pass packets on.
// RL4: A broadcast packet is both delivered locally and forwarded onward; the code delivers it locally only in the online state.
// RL5: Packets toward an inactive outgoing segment are discarded, not forwarded.
// RL6: Forwarding completes within 300 ms when the outgoing segment is active.
// RL7: Two independent addresses: one toward the line end, one toward the network end.
// RL8: Line termination unit has address 1, network termination unit address 2.
// RL9: At power-up both direction addresses are zero.
// RL10: During sync loss failure in a direction, that direction's address returns to zero.
// RL11: A zero address changes only when a discovery probe from that side is processed.
// RL12: Addressing and hop counts cover up to eight regenerators.
// RL13: On a probe, increment hop count, take count plus two as address, pass it on.
// RL14: Discovery response reports hop count, vendor, version and opposite-direction sync loss.
// RL15: Three states per side: offline on sync loss, discovery, online after address learned.
// RL16: In offline, clearing of sync loss moves the state machine to discovery.
// RL17: Online regenerator answers messages addressed to it by the initiating terminal.
// RL18: An identical independent state machine serves the customer side.
// RL19: A packet with a foreign destination goes to the other side for forwarding.
// RL20: Online, packets to own address or address zero are processed locally.
// RL21: Requests from either flow direction are answered.
// RL22: Retransmission and flow control belong to the terminal units only.
// RL23: Initiators poll inventory after a response, then configure, per element.
// RL24: The network termination unit may probe as soon as its channel is active.
// RL25: A per-direction sync loss failure input drives each side's offline condition.
package regen_pkg;
  localparam int ADDR_W = 4;
  localparam int HOP_W = 4;
  localparam logic [3:0] ADDR_ZERO = 4'h0;
  localparam logic [3:0] ADDR_LINE_TERM = 4'h1; // RL8
  localparam logic [3:0] ADDR_NET_TERM = 4'h2; // RL8
  localparam logic [3:0] ADDR_BCAST = 4'hf;
  localparam logic [3:0] ADDR_HOP_OFFSET = 4'h2;
  localparam logic [3:0] MAX_REGEN = 4'h8;
  // The vendor code value is arbitrary.
  localparam logic [7:0] VENDOR_ID = 8'h5a;
  localparam logic [7:0] EOC_VERSION = 8'h01;
  localparam int CLK_HZ = 40000000;
  localparam int FWD_MAX_MS = 300;
  localparam int FWD_MAX_CYC = (CLK_HZ / 1000) * FWD_MAX_MS;
  localparam int TMR_W = 24;

  typedef enum logic [1:0] {
    REGEN_OFFLINE = 2'b00,
    REGEN_DISCOVERY = 2'b01,
    REGEN_ONLINE = 2'b10
  } regen_state_t;
endpackage : regen_pkg

// ==== hw/regen_pkt_if.sv ====
// Interface carrying one packet descriptor from a receive port to a side handler.
interface regen_pkt_if;
  logic valid;
  logic [3:0] src;
  logic [3:0] dst;
  logic probe;
  logic [3:0] hop;
  modport src_mp (output valid, output src, output dst, output probe, output hop);
  modport dst_mp (input valid, input src, input dst, input probe, input hop);
endinterface : regen_pkt_if

// ==== hw/regen_side.sv ====
// One side state machine with address learning and packet classification.
module regen_side (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sync_loss,
  regen_pkt_if.dst_mp rx,
  output logic [3:0] addr,
  output regen_pkg::regen_state_t state,
  output logic proc,
  output logic fwd,
  output logic [3:0] fwd_hop,
  output logic resp
);
  typedef struct packed {
    regen_pkg::regen_state_t st;
    logic [3:0] addr;
    logic proc;
    logic fwd;
    logic [3:0] hop;
    logic resp;
  } regen_side_t;
  regen_side_t r;
  regen_side_t next_r;
  logic [3:0] inc_hop;

  always_comb begin
    next_r = r;
    next_r.proc = 1'b0;
    next_r.fwd = 1'b0;
    next_r.resp = 1'b0;
    inc_hop = rx.hop + 4'h1; // RL13
    if (sync_loss) begin
      next_r.st = regen_pkg::REGEN_OFFLINE; // RL15 RL25
      next_r.addr = regen_pkg::ADDR_ZERO; // RL10
    end else begin
      unique case (r.st)
        regen_pkg::REGEN_OFFLINE: begin
          next_r.st = regen_pkg::REGEN_DISCOVERY; // RL16
        end
        regen_pkg::REGEN_DISCOVERY, regen_pkg::REGEN_ONLINE: begin
          if (rx.valid && rx.probe) begin
            if (rx.hop < regen_pkg::MAX_REGEN) begin // RL12
              next_r.addr = inc_hop + regen_pkg::ADDR_HOP_OFFSET; // RL11 RL13
              next_r.hop = inc_hop;
              next_r.fwd = 1'b1;
              next_r.resp = 1'b1; // RL14
              next_r.st = regen_pkg::REGEN_ONLINE; // RL15
            end
          end else if (rx.valid) begin
            if (rx.dst == regen_pkg::ADDR_BCAST) begin
              next_r.proc = (r.st == regen_pkg::REGEN_ONLINE); // RL4
              next_r.fwd = 1'b1; // RL4
            end else if (r.st == regen_pkg::REGEN_ONLINE &&
                         (rx.dst == r.addr || rx.dst == regen_pkg::ADDR_ZERO)) begin
              next_r.proc = 1'b1; // RL17 RL20 RL21
            end else begin
              next_r.fwd = 1'b1; // RL19
            end
          end
        end
        default: next_r.st = regen_pkg::REGEN_OFFLINE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{regen_pkg::REGEN_OFFLINE, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0}; // RL9
    end else begin
      r <= next_r;
    end
  end

  assign addr = r.addr;
  assign state = r.st;
  assign proc = r.proc;
  assign fwd = r.fwd;
  assign fwd_hop = r.hop;
  assign resp = r.resp;
endmodule : regen_side

// ==== verif/regen_chk.sv ====
// Checker of the regenerator eoc network layer ports.
module regen_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic net_rx_valid,
  input wire logic net_rx_fcs_ok,
  input wire logic [3:0] net_rx_src,
  input wire logic [3:0] net_rx_dst,
  input wire logic net_rx_probe,
  input wire logic [3:0] net_rx_hop,
  input wire logic [1:0] net_state,
  input wire logic [1:0] cus_state,
  input wire logic [3:0] net_addr,
  input wire logic net_app_valid,
  input wire logic [3:0] net_app_src,
  input wire logic to_cus_fwd,
  input wire logic net_resp,
  input wire logic [3:0] net_resp_hop,
  input wire logic net_resp_loss,
  input wire logic cus_resp_loss
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic tk = net_rx_valid && net_rx_fcs_ok;
  wire logic pr = tk && net_rx_probe && net_rx_hop < 4'h8 && net_state != 2'h0 &&
    !cus_resp_loss;
  wire logic dm = tk && !net_rx_probe && net_state == 2'h2 && !cus_resp_loss;
  a_bad_fcs_drop: assert property (
    net_rx_valid && !net_rx_fcs_ok |=> !net_app_valid && !to_cus_fwd && !net_resp)
    else $error("bad packet used");
  a_probe_addr: assert property (
    pr |=> net_addr == $past(net_rx_hop) + 4'h3) else $error("probe address");
  a_probe_resp: assert property (
    pr |=> net_resp && net_resp_hop == $past(net_rx_hop) + 4'h1) else $error("probe reply");
  a_addr_hold: assert property (
    net_state != 2'h0 && !(tk && net_rx_probe) |=> net_addr == $past(net_addr) ||
    net_addr == 4'h0) else $error("address moved");
  a_offline_zero: assert property (
    net_state == 2'h0 |-> net_addr == 4'h0) else $error("offline address");
  a_own_proc: assert property (
    dm && (net_rx_dst == net_addr || net_rx_dst == 4'h0)
    |=> net_app_valid && !to_cus_fwd && net_app_src == $past(net_rx_src))
    else $error("own packet");
  a_foreign_fwd: assert property (
    dm && net_rx_dst != net_addr && net_rx_dst != 4'h0 && net_rx_dst != 4'hf
    |=> (to_cus_fwd == !net_resp_loss) && !net_app_valid) else $error("foreign packet");
  a_bcast_both: assert property (
    dm && net_rx_dst == 4'hf |=> net_app_valid && (to_cus_fwd == !net_resp_loss))
    else $error("broadcast");
endmodule // regen_chk

bind regen_eoc_net regen_chk u_chk (.*);

// ==== verif/regen_peer.sv ====
// Neighbouring span element that offers packet descriptors to one side.
module regen_peer (
  input wire logic clk,
  output logic valid,
  output logic fcs_ok,
  output logic [3:0] src,
  output logic [3:0] dst,
  output logic probe,
  output logic [3:0] hop
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {valid, fcs_ok, src, dst, probe, hop} = '0;
  // Offers one packet once; it is never sent again by this model.
  task automatic send(input logic [3:0] s, input logic [3:0] d, input logic p,
      input logic [3:0] h, input logic ok);
    @(posedge clk);
    {valid, fcs_ok, src, dst, probe, hop} <= {1'b1, ok, s, d, p, h};
    @(posedge clk);
    valid <= 1'b0;
    {fcs_ok, src, dst, probe, hop} <= ~{ok, s, d, p, h};
  endtask
endmodule // regen_peer

// ==== verif/tb_regen_eoc_network_layer.sv ====
// Testbench of the regenerator eoc network layer.
module tb_regen_eoc_network_layer;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, net_sync_word_loss, cus_sync_word_loss;
  logic net_rx_valid, net_rx_fcs_ok, net_rx_probe, cus_rx_valid, cus_rx_fcs_ok, cus_rx_probe;
  logic [3:0] net_rx_src, net_rx_dst, net_rx_hop, cus_rx_src, cus_rx_dst, cus_rx_hop;
  logic [3:0] net_addr, cus_addr, net_app_src, cus_app_src, to_cus_dst, to_cus_hop;
  logic [3:0] to_net_dst, to_net_hop, net_resp_hop, cus_resp_hop;
  logic [1:0] net_state, cus_state;
  logic net_app_valid, cus_app_valid, to_cus_fwd, to_cus_probe, to_net_fwd, to_net_probe;
  logic net_resp, net_resp_loss, cus_resp, cus_resp_loss, fwd_timeout;
  logic [7:0] resp_vendor, resp_version;
  int failures = 0;
  int cmp_count = 0;
  regen_eoc_net dut (.*);
  regen_peer net_peer (.clk(core_clk), .valid(net_rx_valid), .fcs_ok(net_rx_fcs_ok),
    .src(net_rx_src), .dst(net_rx_dst), .probe(net_rx_probe), .hop(net_rx_hop));
  regen_peer cus_peer (.clk(core_clk), .valid(cus_rx_valid), .fcs_ok(cus_rx_fcs_ok),
    .src(cus_rx_src), .dst(cus_rx_dst), .probe(cus_rx_probe), .hop(cus_rx_hop));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_st(input logic [1:0] n, input logic [1:0] c);
    for (int i = 0; i < 20 && (net_state !== n || cus_state !== c); i++) begin
      @(posedge core_clk);
      #1;
    end
    check({net_state, cus_state}, {n, c});
  endtask
  task automatic t_probe();
    net_peer.send(4'h1, 4'h0, 1'b1, 4'h0, 1'b1);
    #1;
    check(net_addr, 8'h3);
    check({net_resp, net_resp_hop, net_resp_loss}, {1'b1, 4'h1, 1'b0});
    check({to_cus_fwd, to_cus_probe, to_cus_hop}, {2'b11, 4'h1});
    check(resp_vendor, regen_pkg::VENDOR_ID);
    check(resp_version, regen_pkg::EOC_VERSION);
    cus_peer.send(4'h2, 4'h0, 1'b1, 4'h2, 1'b1);
    #1;
    check({cus_addr, net_addr}, {4'h5, 4'h3});
    check({cus_resp, cus_resp_hop, cus_resp_loss, to_net_fwd}, {1'b1, 4'h3, 2'b01});
    check({to_net_hop, to_net_probe}, {4'h3, 1'b1});
    cus_peer.send(4'h2, 4'h0, 1'b1, 4'h8, 1'b1);
    #1;
    check({cus_resp, cus_addr}, {1'b0, 4'h5});
    wait_st(2'h2, 2'h2);
  endtask
  task automatic t_pkts();
    logic [3:0] dl [5] = '{4'h3, 4'h0, 4'h9, 4'hf, 4'h3};
    logic [1:0] ex [5] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b00};
    for (int i = 0; i < 5; i++) begin
      net_peer.send(4'h1, dl[i], 1'b0, 4'h0, i < 4);
      #1;
      check({net_app_valid, to_cus_fwd}, ex[i]);
      check({to_cus_dst, to_cus_probe}, {dl[i], 1'b0});
    end
    check(fwd_timeout, 1'b0);
    cus_peer.send(4'h2, 4'h5, 1'b0, 4'h0, 1'b1);
    #1;
    check({cus_app_valid, cus_app_src, to_net_fwd}, {1'b1, 4'h2, 1'b0});
  endtask
  task automatic t_loss();
    @(posedge core_clk);
    cus_sync_word_loss <= 1'b1;
    wait_st(2'h2, 2'h0);
    check(cus_addr, 8'h0);
    net_peer.send(4'h1, 4'h9, 1'b0, 4'h0, 1'b1);
    #1;
    check(to_cus_fwd, 1'b0);
    net_peer.send(4'h1, 4'h0, 1'b1, 4'h1, 1'b1);
    #1;
    check({net_addr, net_resp_loss, to_cus_fwd}, {4'h4, 2'b10});
    @(posedge core_clk);
    cus_sync_word_loss <= 1'b0;
    wait_st(2'h2, 2'h1);
    check(cus_addr, 8'h0);
  endtask
  initial begin
    rst_n = 1'b0;
    net_sync_word_loss = 1'b0;
    cus_sync_word_loss = 1'b0;
    repeat (8) @(posedge core_clk);
    check({net_addr, cus_addr}, 8'h0);
    rst_n <= 1'b1;
    wait_st(2'h1, 2'h1);
    t_probe();
    t_pkts();
    t_loss();
    report_and_stop();
  end
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
endmodule // tb_regen_eoc_network_layer
